/* File: design/ccp_config_control_pins.v */
// Summary of operation
// [R1] Address-change strobe rises one cycle before each master parallel address change.
// [R2] Mode pins sampled once init goes High; value picks configuration mode.
// [R3] Mode pins weakly pulled up in configuration; open pins mean slave serial.
// [R4] After configuration sel0/sel2 are plain inputs, sel1 an unregistered tristate output; code registers sel1 data and enable.
// [R5] Test data out drives scan data when scan kept, else user tristate output.
// [R6] Test inputs go straight to test logic and may also feed user logic.
// [R7] Without scan keep cell, scan disabled after configuration; test pins released.
// [R8] Active-high in-progress output held High until user I/O active.
// [R9] Active-low in-progress output held Low until user I/O active.
// [R10] Init driven Low during power stabilisation and configuration memory clearing.
// [R11] Configuration never starts while init is held Low externally.
// [R12] Master modes wait an extra 30 to 300 us after init High.
// [R13] Init driven Low during configuration to flag a data error.
// [R14] Init released for user I/O once user I/O are active.
// [R15] Reprogram release: finish clear, one more clear, then wait and release init.
// [R16] Done output signals completion of configuration.
// [R17] Data error suspends loading, holds init Low until reprogram or power cycle.
// [R18] Sampled mode held through configuration, resampled only after a new clear.
`timescale 1ns/10ps
`include "ccp_defs.vh"
module ccp_config_control_pins #(
	parameter ADDR_W = `CCP_ADDR_W,
	parameter WAIT_CYCLES = `CCP_WAIT_CYCLES,
	parameter CLEAR_CYCLES = `CCP_CLEAR_CYCLES
) (
	// Clock, reset, enable
	input wire sys_clk,
	input wire reset,
	input wire clkEn,
	// Control pins from outside
	input wire reprogramPin_n,
	input wire initPinIn,
	input wire cfgModeSel0In,
	input wire cfgModeSel1In,
	input wire cfgModeSel2In,
	// Loader core events (same clock)
	input wire powerStable,
	input wire addrAdvance,
	input wire dataError,
	input wire loadDone,
	input wire scanKeepCell,
	// Test pins and user logic
	input wire tdiPin,
	input wire tckPin,
	input wire tmsPin,
	input wire scanTdo,
	input wire userTdoData,
	input wire userTdoEn,
	input wire userSel1Data,
	input wire userSel1En,
	// Init open-drain pin
	output reg initPinOut,
	output reg initPinOe,
	// Mode pins pull and sel1 output
	output reg modePullUp,
	output reg cfgModeSel1Out,
	output reg cfgModeSel1Oe,
	// Configuration memory address and strobe
	output reg [ADDR_W-1:0] cfgMemAddress,
	output reg addrStrobe,
	// Status pins
	output reg cfgActiveHi,
	output reg cfgActiveLo_n,
	output reg donePin,
	// Mode and state to the loader
	output reg [2:0] cfgMode,
	output reg loadEnable,
	output reg userIoActive,
	// Test port outputs
	output reg tdoOut,
	output reg tdoOe,
	output reg scanEnable,
	output reg testTdi,
	output reg testTck,
	output reg testTms,
	output reg userTdi,
	output reg userTck,
	output reg userTms,
	output reg userSel0,
	output reg userSel2
);

	// One-hot states
	localparam ST_POWER = 7'h01;
	localparam ST_CLEAR = 7'h02;
	localparam ST_CLEAR2 = 7'h04;
	localparam ST_WAIT = 7'h08;
	localparam ST_LOAD = 7'h10;
	localparam ST_ERROR = 7'h20;
	localparam ST_USER = 7'h40;

	// Mode is master when sel0 is Low in this encoding
	function isMaster;
		input [2:0] mode;
		begin
			isMaster = (mode != `CCP_MODE_SLAVE_SERIAL) && (mode[0] == 1'b0);
		end
	endfunction

	function isMasterPar;
		input [2:0] mode;
		begin
			isMasterPar = (mode == `CCP_MODE_MASTER_PAR_UP) || (mode == `CCP_MODE_MASTER_PAR_DN);
		end
	endfunction

	reg [6:0] state_r;
	reg [15:0] clrCnt_r;
	reg [15:0] waitCnt_r;
	reg progSeen_r;
	reg modeValid_r;
	reg addrPend_r;
	reg [ADDR_W-1:0] addrNext_r;
	// Two-flop synchronisers for pins
	reg [6:0] syncA_r;
	reg [6:0] syncB_r;
	wire progN = syncB_r[0];
	wire initIn = syncB_r[1];
	wire [2:0] modePins = {syncB_r[4], syncB_r[3], syncB_r[2]};
	wire tdiS = syncB_r[5];
	wire tckS = syncB_r[6];
	reg tmsA_r;
	reg tmsB_r;
	wire inConfig = (state_r != ST_USER);
	wire scanOn = (!inConfig) ? scanKeepCell : 1'b1;

	// Pin synchronisers
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			syncA_r <= 7'h7F;
			syncB_r <= 7'h7F;
			tmsA_r <= 1'b1;
			tmsB_r <= 1'b1;
		end
		else if (clkEn)
		begin
			syncA_r <= {tckPin, tdiPin, cfgModeSel2In, cfgModeSel1In, cfgModeSel0In, initPinIn, reprogramPin_n};
			syncB_r <= syncA_r;
			tmsA_r <= tmsPin;
			tmsB_r <= tmsA_r;
		end
	end

	// Configuration sequencer
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_r <= ST_POWER;
			clrCnt_r <= 16'h0000;
			waitCnt_r <= 16'h0000;
			progSeen_r <= 1'b0;
			modeValid_r <= 1'b0;
			cfgMode <= `CCP_MODE_SLAVE_SERIAL;
		end
		else if (clkEn)
		begin
			case (state_r)
				ST_POWER:
				begin
					if (powerStable)
					begin
						state_r <= ST_CLEAR;
						clrCnt_r <= 16'h0000;
					end
				end
				ST_CLEAR:
				begin
					if (!progN)
						progSeen_r <= 1'b1;
					if (clrCnt_r == CLEAR_CYCLES - 1)
					begin
						clrCnt_r <= 16'h0000;
						// [R15] Extra clear cycle
						if (progSeen_r && progN)
							state_r <= ST_CLEAR2;
						else if (!progSeen_r && progN)
							state_r <= ST_WAIT;
					end
					else
						clrCnt_r <= clrCnt_r + 16'h0001;
					modeValid_r <= 1'b0;
					waitCnt_r <= 16'h0000;
				end
				ST_CLEAR2:
				begin
					progSeen_r <= 1'b0;
					if (!progN)
					begin
						clrCnt_r <= 16'h0000;
						state_r <= ST_CLEAR;
					end
					else if (clrCnt_r == CLEAR_CYCLES - 1)
					begin
						clrCnt_r <= 16'h0000;
						state_r <= ST_WAIT;
					end
					else
						clrCnt_r <= clrCnt_r + 16'h0001;
				end
				ST_WAIT:
				begin
					// [R11] Hold while init Low
					if (!progN)
						state_r <= ST_CLEAR;
					else if (initIn)
					begin
						// [R2] [R18] Sample, hold mode
						if (!modeValid_r)
						begin
							cfgMode <= modePins;
							modeValid_r <= 1'b1;
						end
						// [R12] Master extra wait
						else if (isMaster(cfgMode) && waitCnt_r < WAIT_CYCLES - 1)
							waitCnt_r <= waitCnt_r + 16'h0001;
						else
							state_r <= ST_LOAD;
					end
				end
				ST_LOAD:
				begin
					if (!progN)
						state_r <= ST_CLEAR;
					// [R17] Suspend on error
					else if (dataError)
						state_r <= ST_ERROR;
					else if (loadDone)
						state_r <= ST_USER;
				end
				ST_ERROR:
				begin
					if (!progN)
						state_r <= ST_CLEAR;
				end
				ST_USER:
				begin
					if (!progN)
						state_r <= ST_CLEAR;
				end
				default: state_r <= ST_POWER;
			endcase
		end
	end

	// Address strobe precedes each address change
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			addrPend_r <= 1'b0;
			addrStrobe <= 1'b0;
			cfgMemAddress <= {ADDR_W{1'b0}};
			addrNext_r <= {ADDR_W{1'b0}};
		end
		else if (clkEn)
		begin
			addrStrobe <= 1'b0;
			addrPend_r <= 1'b0;
			if (state_r != ST_LOAD && state_r != ST_ERROR)
				addrNext_r <= {ADDR_W{1'b0}};
			// [R1] Strobe then change
			else if (isMasterPar(cfgMode) && addrAdvance && !addrPend_r)
			begin
				addrStrobe <= 1'b1;
				addrPend_r <= 1'b1;
				addrNext_r <= addrNext_r + {{(ADDR_W-1){1'b0}}, 1'b1};
			end
			if (addrPend_r)
				cfgMemAddress <= addrNext_r;
		end
	end

	// Pin outputs and status
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			initPinOut <= 1'b0;
			initPinOe <= 1'b1;
			modePullUp <= 1'b1;
			cfgModeSel1Out <= 1'b0;
			cfgModeSel1Oe <= 1'b0;
			cfgActiveHi <= 1'b1;
			cfgActiveLo_n <= 1'b0;
			donePin <= 1'b0;
			loadEnable <= 1'b0;
			userIoActive <= 1'b0;
			tdoOut <= 1'b0;
			tdoOe <= 1'b0;
			scanEnable <= 1'b1;
			testTdi <= 1'b1;
			testTck <= 1'b1;
			testTms <= 1'b1;
			userTdi <= 1'b0;
			userTck <= 1'b0;
			userTms <= 1'b0;
			userSel0 <= 1'b0;
			userSel2 <= 1'b0;
		end
		else if (clkEn)
		begin
			// [R10] Init Low while clearing
			// [R13] Init Low on data error
			// [R14] Init released in user mode
			initPinOut <= 1'b0;
			initPinOe <= (state_r == ST_POWER) || (state_r == ST_CLEAR) || (state_r == ST_CLEAR2) ||
				(state_r == ST_ERROR) || (state_r == ST_LOAD && dataError);
			// [R3] Pull-ups in configuration
			modePullUp <= inConfig;
			// [R4] Mode pins to user after
			cfgModeSel1Out <= userSel1Data;
			cfgModeSel1Oe <= !inConfig && userSel1En;
			userSel0 <= inConfig ? 1'b0 : syncB_r[2];
			userSel2 <= inConfig ? 1'b0 : syncB_r[4];
			// [R8] High until active
			cfgActiveHi <= inConfig;
			// [R9] Low until active
			cfgActiveLo_n <= !inConfig;
			// [R16] Done flag
			donePin <= !inConfig;
			userIoActive <= !inConfig;
			loadEnable <= (state_r == ST_LOAD) && !dataError;
			// [R5] Test data out select
			tdoOut <= scanOn ? scanTdo : userTdoData;
			tdoOe <= scanOn ? 1'b1 : userTdoEn;
			// [R7] Scan off without keep cell
			scanEnable <= scanOn;
			// [R6] Test inputs direct path
			testTdi <= tdiS;
			testTck <= tckS;
			testTms <= scanOn ? tmsB_r : 1'b1;
			userTdi <= inConfig ? 1'b0 : tdiS;
			userTck <= inConfig ? 1'b0 : tckS;
			userTms <= inConfig ? 1'b0 : tmsB_r;
		end
	end

endmodule // ccp_config_control_pins

/* File: design/ccp_defs.vh */
`ifndef CCP_DEFS_VH
`define CCP_DEFS_VH
// Address width of configuration memory
`define CCP_ADDR_W 18
// Mode encodings (sel2, sel1, sel0)
`define CCP_MODE_SLAVE_SERIAL 3'h7
`define CCP_MODE_MASTER_SERIAL 3'h0
`define CCP_MODE_MASTER_PAR_UP 3'h4
`define CCP_MODE_MASTER_PAR_DN 3'h6
// Master wait window in microseconds
`define CCP_WAIT_MIN_US 30
`define CCP_WAIT_MAX_US 300
// Clock rate in MHz
`define CCP_CLK_MHZ 20
// Wait count: least time rounded up (30 us at 20 MHz)
`define CCP_WAIT_CYCLES (`CCP_WAIT_MIN_US * `CCP_CLK_MHZ)
// Clear cycle length in clocks
`define CCP_CLEAR_CYCLES 64
`endif

/* File: sim/ccp_checker.sv */
`timescale 1ns/10ps
module ccp_checker #(
	parameter ADDR_W = 18
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Watched pins
	input wire logic initPinIn,
	input wire logic initPinOe,
	input wire logic dataError,
	input wire logic loadDone,
	input wire logic loadEnable,
	input wire logic addrStrobe,
	input wire logic [ADDR_W-1:0] cfgMemAddress,
	input wire logic cfgActiveHi,
	input wire logic cfgActiveLo_n,
	input wire logic donePin,
	input wire logic modePullUp,
	input wire logic [2:0] cfgMode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Init held low outside loading
	sequence initHeld;
		(!initPinIn && !loadEnable) [*4];
	endsequence
	// Loader reports the end
	sequence loadFinish;
		loadEnable && loadDone && !dataError;
	endsequence
	chk_addr_step: assert property (addrStrobe |=> cfgMemAddress == $past(cfgMemAddress) + 1'b1)
		else $error("Address did not step after strobe");
	chk_addr_cause: assert property ($changed(cfgMemAddress) |-> $past(addrStrobe))
		else $error("Address changed without strobe");
	chk_busy_pins: assert property (!donePin |-> cfgActiveHi && !cfgActiveLo_n)
		else $error("Busy pins wrong before done");
	chk_init_free: assert property (donePin |-> !initPinOe)
		else $error("Init driven in user mode");
	chk_pull_cfg: assert property (loadEnable |-> modePullUp)
		else $error("Mode pull-ups off while loading");
	chk_mode_hold: assert property (loadEnable && $past(loadEnable) |-> $stable(cfgMode))
		else $error("Mode changed while loading");
	chk_wait_init: assert property (initHeld |=> !loadEnable)
		else $error("Load began with init low");
	chk_error_flag: assert property (loadEnable && dataError |-> ##[1:3] initPinOe)
		else $error("Data error not flagged on init");
	chk_done_out: assert property (loadFinish |-> ##[1:3] donePin)
		else $error("Done did not rise");
endmodule // ccp_checker
bind ccp_config_control_pins ccp_checker #(.ADDR_W(ADDR_W)) ccp_checker_inst (.sys_clk, .reset, .initPinIn,
	.initPinOe, .dataError, .loadDone, .loadEnable, .addrStrobe, .cfgMemAddress, .cfgActiveHi, .cfgActiveLo_n,
	.donePin, .modePullUp, .cfgMode);

/* File: sim/ccp_host_model.sv */
`timescale 1ns/10ps
module ccp_host_model (
	// Device side
	input wire logic initPinOe,
	input wire logic modePullUp,
	// Host commands
	input wire logic holdInit,
	input wire logic strapOn,
	input wire logic [2:0] strapVal,
	// Resolved wires
	output logic initPinIn,
	output logic [2:0] modePins
);
	assign initPinIn = !(initPinOe || holdInit);
	assign modePins = strapOn ? strapVal : (modePullUp ? 3'h7 : 3'h5);
endmodule // ccp_host_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
	// Stimulus
	logic sys_clk = 0, reset = 1, holdInit = 0, strapOn = 0, reprogramPin_n = 1, powerStable = 0;
	logic addrAdvance = 0, dataError = 0, loadDone = 0, scanKeepCell = 0, tdiPin = 0, tckPin = 0, tmsPin = 0;
	logic scanTdo = 0, userTdoData = 0, userTdoEn = 0, userSel1Data = 0, userSel1En = 0;
	// Master wait length handed to the device
	localparam int WAIT = 5;
	logic [2:0] strapVal = 3'h0;
	// Device outputs
	wire initPinIn, initPinOe, modePullUp, addrStrobe, cfgActiveHi, cfgActiveLo_n, donePin, loadEnable;
	wire scanEnable, userTdi, tdoOut, tdoOe;
	wire initPinOut, cfgModeSel1Out, cfgModeSel1Oe, userIoActive, testTdi, testTck, testTms;
	wire userTck, userTms, userSel0, userSel2;
	wire [2:0] modePins, cfgMode;
	wire [17:0] cfgMemAddress;
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	ccp_config_control_pins #(.WAIT_CYCLES(WAIT), .CLEAR_CYCLES(4)) ccp_config_control_pins_inst (
		.sys_clk, .reset, .clkEn(1'b1), .reprogramPin_n, .initPinIn, .cfgModeSel0In(modePins[0]),
		.cfgModeSel1In(modePins[1]), .cfgModeSel2In(modePins[2]), .powerStable, .addrAdvance, .dataError,
		.loadDone, .scanKeepCell, .tdiPin, .tckPin, .tmsPin, .scanTdo, .userTdoData, .userTdoEn,
		.userSel1Data, .userSel1En, .initPinOut, .initPinOe, .modePullUp, .cfgModeSel1Out,
		.cfgModeSel1Oe, .cfgMemAddress, .addrStrobe, .cfgActiveHi, .cfgActiveLo_n, .donePin, .cfgMode,
		.loadEnable, .userIoActive, .tdoOut, .tdoOe, .scanEnable, .testTdi, .testTck, .testTms,
		.userTdi, .userTck, .userTms, .userSel0, .userSel2);
	ccp_host_model ccp_host_model_inst (.initPinOe, .modePullUp, .holdInit, .strapOn, .strapVal,
		.initPinIn, .modePins);
	// Clock
	initial forever #25 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	task cmp(input logic [17:0] got, input logic [17:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Reset, power up and park in wait
	task boot(input logic on, input logic [2:0] v);
		strapOn = on;
		strapVal = v;
		holdInit = 1;
		reset = 1;
		powerStable = 0;
		tick(8);
		reset = 0;
		tick(3);
		cmp(initPinOe, 1, "init free in power");
		powerStable = 1;
		tick(3);
		cmp(initPinOe, 1, "init free in clear");
		tick(20);
	endtask
	task wait_load(output int n);
		holdInit = 0;
		n = 0;
		while (!loadEnable && n < 50)
		begin
			tick(1);
			n++;
		end
	endtask
	task step();
		addrAdvance = 1;
		tick(1);
		addrAdvance = 0;
		cmp(addrStrobe, 1, "no strobe");
		tick(1);
	endtask
	task end_load();
		loadDone = 1;
		tick(1);
		loadDone = 0;
		tick(3);
		cmp(donePin, 1, "no done");
		cmp(initPinOe, 0, "init kept");
	endtask
	task t_slave();
		int n;
		userTdoData = 1;
		userTdoEn = 1;
		userSel1Data = 1;
		userSel1En = 1;
		boot(0, 3'h0);
		cmp(loadEnable, 0, "load while held");
		cmp({cfgActiveHi, cfgActiveLo_n}, 2'h2, "busy pins");
		cmp({userSel2, userSel0, cfgModeSel1Oe}, 3'h0, "mode pins leaked");
		cmp({tdoOe, tdoOut}, 2'h2, "scan out in config");
		cmp(initPinOut, 0, "init drives high");
		wait_load(n);
		// Two sync stages, sample, load state, load flag
		cmp(n, 5, "slave wait");
		cmp(cfgMode, 3'h7, "open straps");
		end_load();
		cmp({cfgModeSel1Oe, cfgModeSel1Out, tdoOe, tdoOut}, 4'hF, "user outputs");
		cmp({modePullUp, userIoActive}, 2'h1, "user state");
		userTdoData = 0;
		userTdoEn = 0;
		userSel1En = 0;
		strapOn = 1;
		strapVal = 3'h4;
		tdiPin = 1;
		tckPin = 1;
		tmsPin = 1;
		tick(4);
		cmp({cfgModeSel1Oe, tdoOe, tdoOut}, 3'h0, "user outputs off");
		cmp({userSel2, userSel0}, 2'h2, "mode pins to user");
		cmp({scanEnable, userTdi}, 2'h1, "test pins");
		cmp({userTck, userTms, testTdi, testTck, testTms}, 5'h1F, "test pin paths");
	endtask
	task t_master();
		int n;
		boot(1, 3'h4);
		wait_load(n);
		// Slave path plus the extra master wait cycles
		cmp(n, 4 + WAIT, "master wait");
		strapVal = 3'h0;
		tick(4);
		step();
		cmp(cfgMemAddress, 18'h00001, "addr step");
		cmp(cfgMode, 3'h4, "mode resampled");
		dataError = 1;
		tick(1);
		dataError = 0;
		tick(2);
		cmp(initPinOe, 1, "no error flag");
		step();
		tick(10);
		cmp(initPinOe, 1, "error state init");
		cmp(cfgMemAddress, 18'h00002, "error state address");
		reprogramPin_n = 0;
		tick(6);
		reprogramPin_n = 1;
		tick(4);
		cmp(initPinOe, 1, "short clear");
		tick(20);
		cmp(initPinOe, 0, "init not freed");
	endtask
	task t_scan();
		int n;
		scanKeepCell = 1;
		boot(0, 3'h0);
		wait_load(n);
		end_load();
		scanTdo = 1;
		tmsPin = 0;
		tick(3);
		cmp({scanEnable, tdoOe, tdoOut}, 3'h7, "scan out");
		cmp(testTms, 0, "scan mode select");
	endtask
	// Main sequence
	initial
	begin
		t_slave();
		t_master();
		t_scan();
		stop_test();
	end
endmodule // testbench
